// File: rtl/vdla_pkg.sv
package vdla_pkg;
    // APB register map (word aligned byte addresses)
    localparam logic [11:0] OFF_ROM_TIMING = 12'h000;
    localparam logic [11:0] OFF_MEM_CFG = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_LAST_CYCLES = 12'h00C;
    // Reset values
    localparam logic [4:0] ROM_TIMING_RST = 5'h00;
    localparam logic [2:0] MEM_CFG_RST = 3'h1;
    // Field positions in rom_timing_control
    localparam int ROM_NSEQ_LSB = 0;
    localparam int ROM_BURST_LSB = 3;
    // Field positions in memory configuration register
    localparam int CFG_ROM16 = 0;
    localparam int CFG_HALFSPD = 1;
    localparam int CFG_DRAM16 = 2;
    // Cycle counts
    localparam logic [3:0] ROM_NSEQ_BASE = 4'h7;
    localparam logic [3:0] ROM_BURST_BASE = 4'h5;
    localparam logic [4:0] REG_BURST_CYCLES = 5'h10;
    localparam logic [4:0] REG_ACCESS_CYCLES = 5'h04;
    localparam logic [4:0] DRAM16_SEQ_CYCLES = 5'h13;
    localparam logic [4:0] DRAM32_ACCESS_CYCLES = 5'h05;
    localparam logic [4:0] DRAM_SEQ_CYCLES = 5'h02;
    localparam logic [4:0] IO_ACCESS_CYCLES = 5'h04;
    localparam logic [2:0] GROUP_LEN = 3'h4;
    // Latency figures in half cycles
    localparam int SYNC_HALF_CYCLES = 11;
    localparam int DATA_HALF_CYCLES = 7;
    localparam logic [2:0] SYNC_CYCLES = 3'(SYNC_HALF_CYCLES / 2);
    localparam logic [2:0] DATA_CYCLES = 3'((DATA_HALF_CYCLES + 1) / 2);
    // Address decode
    localparam int PHYS_ADDR_BITS = 29;
    localparam logic [28:0] BASE_ROM1 = 29'h0100_0000;
    localparam logic [28:0] BASE_RSVD2 = 29'h0200_0000;
    localparam logic [28:0] BASE_MODIO = 29'h0300_0000;
    localparam logic [28:0] BASE_PCIO = 29'h0301_0000;
    localparam logic [28:0] BASE_RSVD_PC = 29'h0302_C000;
    localparam logic [28:0] BASE_MODIO2 = 29'h0303_0000;
    localparam logic [28:0] BASE_RSVD_M = 29'h0304_0000;
    localparam logic [28:0] BASE_CHIPREG = 29'h0320_0000;
    localparam logic [28:0] BASE_SIMPIO = 29'h0321_0000;
    localparam logic [28:0] BASE_VIDREG = 29'h0340_0000;
    localparam logic [28:0] BASE_RSVD_V = 29'h0350_0000;
    localparam logic [28:0] BASE_RSVD4 = 29'h0400_0000;
    localparam logic [28:0] BASE_EXTIO = 29'h0800_0000;
    localparam logic [28:0] BASE_DRAM = 29'h1000_0000;
    localparam logic [31:0] BASE_ROMALIAS = 32'h2000_0000;
    // Decoded space classes
    typedef enum logic [3:0] {
        VDLA_SP_ROM = 4'h0,
        VDLA_SP_DRAM = 4'h1,
        VDLA_SP_IO = 4'h2,
        VDLA_SP_REG = 4'h3,
        VDLA_SP_RSVD = 4'h4
    } vdla_space_e;
    typedef enum logic [3:0] {
        VDLA_G_NONE = 4'h0,
        VDLA_G_VIDEO = 4'h1,
        VDLA_G_SOUND = 4'h2,
        VDLA_G_REFRESH = 4'h4,
        VDLA_G_CPU = 4'h8
    } vdla_grant_e;
endpackage

// File: rtl/vdla_addr_decode.sv
`timescale 1ns/1ns
`default_nettype none
module vdla_addr_decode
    import vdla_pkg::*;
(
    input wire logic [31:0] physAddr,
    output vdla_space_e space,
    output logic [1:0] bank,
    output logic [2:0] ioRegion
);
    logic [28:0] a;
    assign a = physAddr[PHYS_ADDR_BITS-1:0];

    // Range decode from the top down; ioRegion numbers the window's areas
    always_comb begin
        space = VDLA_SP_RSVD;
        bank = 2'h0;
        ioRegion = 3'h0;
        // Bit 29 is dropped, so the repeat of ROM bank 0 needs no compare
        if (a >= BASE_DRAM) begin
            space = VDLA_SP_DRAM;
            bank = a[27:26];
        end else if (a >= BASE_EXTIO) begin
            space = VDLA_SP_IO;
            ioRegion = 3'h6;
        end else if (a >= BASE_RSVD_V) begin
            space = VDLA_SP_RSVD;
        end else if (a >= BASE_VIDREG) begin
            space = VDLA_SP_REG;
            ioRegion = 3'h5;
        end else if (a >= BASE_SIMPIO) begin
            space = VDLA_SP_IO;
            ioRegion = 3'h4;
        end else if (a >= BASE_CHIPREG) begin
            space = VDLA_SP_REG;
            ioRegion = 3'h3;
        end else if (a >= BASE_RSVD_M) begin
            space = VDLA_SP_RSVD;
        end else if (a >= BASE_MODIO2) begin
            space = VDLA_SP_IO;
            ioRegion = 3'h2;
        end else if (a >= BASE_RSVD_PC) begin
            space = VDLA_SP_RSVD;
        end else if (a >= BASE_PCIO) begin
            space = VDLA_SP_IO;
            ioRegion = 3'h1;
        end else if (a >= BASE_MODIO) begin
            space = VDLA_SP_IO;
        end else if (a >= BASE_RSVD2) begin
            space = VDLA_SP_RSVD;
        end else if (a >= BASE_ROM1) begin
            space = VDLA_SP_ROM;
            bank = 2'h1;
        end else begin
            space = VDLA_SP_ROM;
        end
    end
endmodule // vdla_addr_decode
`default_nettype wire

// File: rtl/vdla_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module vdla_arbiter
    import vdla_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic videoReq,
    input wire logic soundReq,
    input wire logic refreshReq,
    input wire logic cpuReq,
    input wire logic cpuSeq,
    input wire logic [31:0] cpuAddr,
    output logic videoGrant,
    output logic soundGrant,
    output logic refreshGrant,
    output logic cpuGrant,
    output logic cpuDone,
    output logic videoDataStrobe,
    output logic [3:0] cycleSpace
);
    // Reset released through two flops; assertion stays asynchronous,
    // release is clocked so no flop sees reset end in mid-edge
    logic rstMeta_reg;
    logic rstSync_reg;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end
    logic rstN;
    assign rstN = rstSync_reg;

    // Control registers
    logic [4:0] romTiming_reg;
    logic [2:0] memCfg_reg;
    logic [4:0] lastCycles_reg;

    // APB: zero wait states, pready high in every cycle after reset
    logic apbWr;
    logic apbRd;
    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && !penable && !pwrite;
    // Writes land in the access phase; setup only carries the address
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            romTiming_reg <= ROM_TIMING_RST;
            memCfg_reg <= MEM_CFG_RST;
        end else if (apbWr) begin
            if (paddr == OFF_ROM_TIMING) begin
                romTiming_reg <= pwdata[4:0];
            end else if (paddr == OFF_MEM_CFG) begin
                memCfg_reg <= pwdata[2:0];
            end
        end
    end

    // Arbiter state
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DMA = 4'b0010,
        ST_CPU = 4'b0100,
        ST_IOHOLD = 4'b1000
    } vdla_state_e;
    vdla_state_e state_reg;
    logic [4:0] cnt_reg;
    logic [2:0] groupCnt_reg;
    logic [3:0] grant_reg;
    logic [2:0] dataCnt_reg;
    logic [2:0] videoSync_reg;
    logic videoSeen_reg;
    logic ioPaused_reg;
    logic [4:0] ioLeft_reg;

    // A zero count would wrap a down-counter and hold the bus 32 cycles
    if (DATA_CYCLES == 3'h0 || GROUP_LEN == 3'h0) begin : g_count_check
        $error("data and group counts must not be zero");
    end

    // Video request pipeline: the sync flops plus the missed idle slot
    // make up the 5.5 clock term; no input is read before its last stage
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            videoSync_reg <= 3'h0;
        end else begin
            videoSync_reg <= {videoSync_reg[1:0], videoReq};
        end
    end
    logic videoPend;
    assign videoPend = videoSync_reg[2] && !videoSeen_reg;

    // ROM cycle cost, counted on bus clock since prescale is one
    // Codes 110 and 111 give one and zero cycles before romShift; software must avoid them
    logic [4:0] romNseq;
    logic [4:0] romBurst;
    logic [1:0] romShift;
    assign romShift = {1'b0, memCfg_reg[CFG_ROM16]}
        + {1'b0, memCfg_reg[CFG_HALFSPD]};
    assign romNseq = 5'(ROM_NSEQ_BASE - 4'(romTiming_reg[2:0])) << romShift;
    assign romBurst = 5'(ROM_BURST_BASE - 4'(romTiming_reg[4:3])) << romShift;

    vdla_space_e space;
    logic [1:0] bankUnused;
    logic [2:0] ioRegion;
    vdla_addr_decode u_decode (
        .physAddr(cpuAddr),
        .space(space),
        .bank(bankUnused),
        .ioRegion(ioRegion)
    );

    // Cost and whether a sequential follow-on keeps the bus
    logic [4:0] cpuCost;
    logic seqAllowed;
    always_comb begin
        cpuCost = DRAM32_ACCESS_CYCLES;
        seqAllowed = 1'b0;
        case (space)
            VDLA_SP_ROM: begin
                seqAllowed = romTiming_reg[4:3] != 2'h0;
                cpuCost = (cpuSeq && seqAllowed) ? romBurst : romNseq;
            end
            VDLA_SP_DRAM: begin
                seqAllowed = 1'b1;
                if (memCfg_reg[CFG_DRAM16]) begin
                    // The whole 16-bit sequence is one hold; never chain it
                    seqAllowed = 1'b0;
                    cpuCost = DRAM16_SEQ_CYCLES;
                end else begin
                    cpuCost = cpuSeq ? DRAM_SEQ_CYCLES : DRAM32_ACCESS_CYCLES;
                end
            end
            VDLA_SP_REG: begin
                seqAllowed = 1'b1;
                cpuCost = REG_ACCESS_CYCLES;
            end
            default: begin
                cpuCost = IO_ACCESS_CYCLES;
            end
        endcase
    end

    // Processor keeps the bus only for a sequential access inside a group
    // Trade-off: a sequential stream may keep DMA out for a whole group
    logic cpuKeeps;
    assign cpuKeeps = cpuReq && cpuSeq && seqAllowed
        && groupCnt_reg < GROUP_LEN;

    // Main arbitration; DMA enters at an idle point, and video also during an I/O hold
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 5'h00;
            groupCnt_reg <= 3'h0;
            grant_reg <= VDLA_G_NONE;
            lastCycles_reg <= 5'h00;
            videoSeen_reg <= 1'b0;
            ioPaused_reg <= 1'b0;
            ioLeft_reg <= 5'h00;
        end else begin
            if (!videoSync_reg[2]) begin
                videoSeen_reg <= 1'b0;
            end
            case (state_reg)
                // Priority is the order of the if-chain at the idle point
                ST_IDLE: begin
                    groupCnt_reg <= 3'h0;
                    if (videoPend) begin
                        grant_reg <= VDLA_G_VIDEO;
                        videoSeen_reg <= 1'b1;
                        cnt_reg <= 5'(DATA_CYCLES);
                        state_reg <= ST_DMA;
                    end else if (soundReq) begin
                        grant_reg <= VDLA_G_SOUND;
                        cnt_reg <= 5'(DATA_CYCLES);
                        state_reg <= ST_DMA;
                    end else if (refreshReq) begin
                        grant_reg <= VDLA_G_REFRESH;
                        cnt_reg <= 5'(DATA_CYCLES);
                        state_reg <= ST_DMA;
                    end else if (cpuReq) begin
                        grant_reg <= VDLA_G_CPU;
                        cnt_reg <= cpuCost;
                        lastCycles_reg <= cpuCost;
                        groupCnt_reg <= 3'h1;
                        state_reg <= (space == VDLA_SP_IO)
                            ? ST_IOHOLD : ST_CPU;
                    end else begin
                        grant_reg <= VDLA_G_NONE;
                    end
                end
                ST_DMA: begin
                    // Fixed-length slot; the requester drops its own level
                    cnt_reg <= cnt_reg - 5'h01;
                    if (cnt_reg == 5'h01 && ioPaused_reg) begin
                        // Hand the held I/O cycle back its remaining count
                        grant_reg <= VDLA_G_CPU;
                        cnt_reg <= ioLeft_reg;
                        ioPaused_reg <= 1'b0;
                        state_reg <= ST_IOHOLD;
                    end else if (cnt_reg == 5'h01) begin
                        grant_reg <= VDLA_G_NONE;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_CPU: begin
                    // Cycle runs to its end before any DMA
                    cnt_reg <= cnt_reg - 5'h01;
                    if (cnt_reg == 5'h01) begin
                        if (cpuKeeps) begin
                            cnt_reg <= cpuCost;
                            lastCycles_reg <= cpuCost;
                            groupCnt_reg <= groupCnt_reg + 3'h1;
                        end else begin
                            grant_reg <= VDLA_G_NONE;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_IOHOLD: begin
                    // Data latched; video may borrow the bus mid-cycle
                    if (videoPend) begin
                        // Park the I/O count; its end waits for the DMA
                        ioPaused_reg <= 1'b1;
                        ioLeft_reg <= cnt_reg;
                        grant_reg <= VDLA_G_VIDEO;
                        videoSeen_reg <= 1'b1;
                        cnt_reg <= 5'(DATA_CYCLES);
                        state_reg <= ST_DMA;
                    end else begin
                        cnt_reg <= cnt_reg - 5'h01;
                        if (cnt_reg == 5'h01) begin
                            grant_reg <= VDLA_G_NONE;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Data strobe counter for the first video word; loaded at the edge of
    // the grant decision at either arbitration point
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            dataCnt_reg <= 3'h0;
            videoDataStrobe <= 1'b0;
        end else begin
            videoDataStrobe <= 1'b0;
            if ((state_reg == ST_IDLE || state_reg == ST_IOHOLD)
                && videoPend) begin
                dataCnt_reg <= DATA_CYCLES;
            end else if (dataCnt_reg != 3'h0) begin
                dataCnt_reg <= dataCnt_reg - 3'h1;
                videoDataStrobe <= dataCnt_reg == 3'h1;
            end
        end
    end

    // Registered outputs; each lags its decision by one cycle so every
    // top-level output leaves a flop
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            videoGrant <= 1'b0;
            soundGrant <= 1'b0;
            refreshGrant <= 1'b0;
            cpuGrant <= 1'b0;
            cpuDone <= 1'b0;
            cycleSpace <= 4'h0;
        end else begin
            videoGrant <= grant_reg[0];
            soundGrant <= grant_reg[1];
            refreshGrant <= grant_reg[2];
            cpuGrant <= grant_reg[3];
            cpuDone <= (state_reg == ST_CPU || state_reg == ST_IOHOLD)
                && cnt_reg == 5'h01;
            cycleSpace <= {1'b0, ioRegion} ^ 4'(space);
        end
    end

    // APB read data registered in the setup cycle
    // Errors for unmapped or read-only targets are also set in setup
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (apbRd) begin
                pslverr <= 1'b0;
                if (paddr == OFF_ROM_TIMING) begin
                    prdata <= {27'h0, romTiming_reg};
                end else if (paddr == OFF_MEM_CFG) begin
                    prdata <= {29'h0, memCfg_reg};
                end else if (paddr == OFF_STATUS) begin
                    prdata <= {24'h0, grant_reg, state_reg};
                end else if (paddr == OFF_LAST_CYCLES) begin
                    prdata <= {27'h0, lastCycles_reg};
                end else begin
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            end else if (psel && !penable) begin
                pslverr <= !(paddr == OFF_ROM_TIMING
                    || paddr == OFF_MEM_CFG);
            end
        end
    end
endmodule // vdla_arbiter
`default_nettype wire

// File: testbench/vdla_arbiter_sva.sv
`timescale 1ns/1ns
`default_nettype none
module vdla_arbiter_sva
    import vdla_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic videoReq,
    input wire logic cpuReq,
    input wire logic videoGrant,
    input wire logic soundGrant,
    input wire logic refreshGrant,
    input wire logic cpuGrant,
    input wire logic cpuDone,
    input wire logic videoDataStrobe
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Bus ownership: one owner, owned only on request, released on done
    chk_grant_one_hot: assert property (
        $onehot0({videoGrant, soundGrant, refreshGrant, cpuGrant}))
        else $error("grants overlap");
    chk_grant_has_req: assert property (
        $rose(cpuGrant) |-> $past(cpuReq))
        else $error("processor granted without request");
    chk_cycle_ends_done: assert property (
        $fell(cpuGrant) |-> $past(cpuDone))
        else $error("processor cycle cut short");
    chk_cpu_cost_bound: assert property (
        $rose(cpuGrant) |-> ##[0:28] cpuDone)
        else $error("processor cycle longer than slowest ROM");

    // Video latency: synchronising, then the first data word
    chk_video_sync_bound: assert property (
        $rose(videoReq) && !cpuReq && !cpuGrant |-> ##[1:6] videoGrant)
        else $error("video request not synchronised in time");
    chk_first_word_delay: assert property (
        $rose(videoGrant) |-> ##[3:4] videoDataStrobe)
        else $error("first video word late");

    // Register port answers at once; unmapped space errors and reads zero
    chk_apb_no_wait: assert property (
        psel && penable |-> pready)
        else $error("register access stalled");
    chk_unmapped_err: assert property (
        psel && penable && paddr > OFF_LAST_CYCLES |-> pslverr)
        else $error("unmapped access without error");
    chk_unmapped_zero: assert property (
        psel && penable && !pwrite && paddr > OFF_LAST_CYCLES
        |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule // vdla_arbiter_sva

bind vdla_arbiter vdla_arbiter_sva chk (.mclk(mclk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .videoReq(videoReq), .cpuReq(cpuReq), .videoGrant(videoGrant),
    .soundGrant(soundGrant), .refreshGrant(refreshGrant),
    .cpuGrant(cpuGrant), .cpuDone(cpuDone),
    .videoDataStrobe(videoDataStrobe));
`default_nettype wire

// File: testbench/vdla_partner.sv
`timescale 1ns/1ns
`default_nettype none
module vdla_partner
(
    input wire logic mclk,
    input wire logic cpuGo,
    input wire logic cpuSeqIn,
    input wire logic [31:0] cpuAddrIn,
    input wire logic videoGo,
    input wire logic cpuDone,
    input wire logic cpuGrant,
    input wire logic videoDataStrobe,
    output logic cpuReq,
    output logic cpuSeq,
    output logic [31:0] cpuAddr,
    output logic videoReq
);
    initial begin
        cpuReq = 1'b0;
        cpuSeq = 1'b0;
        cpuAddr = 32'h0000_0000;
        videoReq = 1'b0;
    end

    // A request is dropped once its grant shows, since the arbiter looks
    // again in the idle cycle that carries cpuDone; address and kind stand
    // until done, then are scrambled so a late sample sees a wrong value
    always @(posedge mclk) begin
        if (cpuGo) begin
            cpuReq <= 1'b1;
            cpuSeq <= cpuSeqIn;
            cpuAddr <= cpuAddrIn;
        end else begin
            if (cpuGrant) begin
                cpuReq <= 1'b0;
            end
            if (cpuDone) begin
                cpuSeq <= ~cpuSeq;
                cpuAddr <= ~cpuAddr;
            end
        end
        if (videoGo) begin
            videoReq <= 1'b1;
        end else if (videoDataStrobe) begin
            videoReq <= 1'b0;
        end
    end
endmodule // vdla_partner
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import vdla_pkg::*;
;
    typedef struct packed {
        logic [4:0] tim;
        logic [2:0] cfg;
        logic [31:0] addr;
        logic seq;
        logic [4:0] cost;
    } vdla_row_s;
    // Timing code, config, address, sequential, expected cycle cost
    vdla_row_s rows [16] = '{
        '{5'h00, 3'h0, 32'h0000_0000, 1'b0, 5'h07},
        '{5'h01, 3'h0, 32'h0000_0000, 1'b0, 5'h06},
        '{5'h02, 3'h0, 32'h0000_0000, 1'b0, 5'h05},
        '{5'h03, 3'h0, 32'h0000_0000, 1'b0, 5'h04},
        '{5'h04, 3'h0, 32'h0000_0000, 1'b0, 5'h03},
        '{5'h05, 3'h0, 32'h0000_0000, 1'b0, 5'h02},
        '{5'h00, 3'h1, 32'h0000_0000, 1'b0, 5'h0E},
        '{5'h00, 3'h3, 32'h0000_0000, 1'b0, 5'h1C},
        '{5'h08, 3'h0, 32'h0100_0000, 1'b1, 5'h04},
        '{5'h10, 3'h0, 32'h0100_0000, 1'b1, 5'h03},
        '{5'h18, 3'h2, 32'h0100_0000, 1'b1, 5'h04},
        '{5'h05, 3'h0, 32'h2000_0000, 1'b0, 5'h02},
        '{5'h05, 3'h0, 32'h1C00_0000, 1'b0, 5'h05},
        '{5'h05, 3'h4, 32'h1000_0000, 1'b0, 5'h13},
        '{5'h05, 3'h0, 32'h0303_0000, 1'b0, 5'h04},
        '{5'h05, 3'h0, 32'h0320_0000, 1'b0, 5'h04}};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000, prdata, cpuAddr;
    logic [31:0] cpuAddrIn = 32'h0000_0000;
    logic pready, pslverr, videoReq, cpuReq, cpuSeq, cpuDone;
    logic soundReq = 1'b0, refreshReq = 1'b0;
    logic cpuGo = 1'b0, cpuSeqIn = 1'b0, videoGo = 1'b0;
    logic videoGrant, soundGrant, refreshGrant, cpuGrant, videoDataStrobe;
    int failCount = 0;
    int checkCount = 0;
    wire logic [5:0] watch = {videoDataStrobe, cpuDone, cpuGrant,
        refreshGrant, soundGrant, videoGrant};

    always #25 mclk = ~mclk;

    vdla_arbiter DUT (.mclk(mclk), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .videoReq(videoReq), .soundReq(soundReq), .refreshReq(refreshReq),
        .cpuReq(cpuReq), .cpuSeq(cpuSeq), .cpuAddr(cpuAddr),
        .videoGrant(videoGrant), .soundGrant(soundGrant),
        .refreshGrant(refreshGrant), .cpuGrant(cpuGrant), .cpuDone(cpuDone),
        .videoDataStrobe(videoDataStrobe), .cycleSpace());
    vdla_partner far (.mclk(mclk), .cpuGo(cpuGo), .cpuSeqIn(cpuSeqIn),
        .cpuAddrIn(cpuAddrIn), .videoGo(videoGo), .cpuDone(cpuDone),
        .cpuGrant(cpuGrant),
        .videoDataStrobe(videoDataStrobe), .cpuReq(cpuReq), .cpuSeq(cpuSeq),
        .cpuAddr(cpuAddr), .videoReq(videoReq));

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrapUp();
        if (failCount == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Counts falling edges until a masked line is high; falling edge
    // sampling sees settled outputs, never a same-edge race
    task automatic waitFor(input logic [5:0] mask, output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
            if (n > 300) begin
                failCount++;
                wrapUp();
            end
        end while ((watch & mask) == 6'h00);
    endtask

    // One register transfer: setup, then access until ready is seen
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Ready, data and error are taken at the edge ending the access
        do begin
            @(posedge mclk);
            n++;
            if (n > 300) begin
                failCount++;
                wrapUp();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Hands a processor request to the far-side model
    task automatic cpuStart(input logic [31:0] a, input logic s);
        @(posedge mclk);
        cpuGo <= 1'b1;
        cpuAddrIn <= a;
        cpuSeqIn <= s;
        @(posedge mclk);
        cpuGo <= 1'b0;
    endtask

    task automatic pulseReset();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    initial begin
        int n;
        logic [31:0] rd;
        logic err;
        pulseReset();
        apb(1'b0, OFF_ROM_TIMING, 32'h0, rd, err);
        check("romTiming", rd, 32'(ROM_TIMING_RST));
        apb(1'b0, OFF_MEM_CFG, 32'h0, rd, err);
        check("memCfg", rd, 32'(MEM_CFG_RST));
        apb(1'b0, 12'h010, 32'h0, rd, err);
        check("unmappedErr", 32'(err), 32'h1);
        apb(1'b1, OFF_STATUS, 32'h0000_000F, rd, err);
        check("readOnlyErr", 32'(err), 32'h1);
        // Cycle cost of each access kind, read back after it completes
        foreach (rows[i]) begin
            apb(1'b1, OFF_ROM_TIMING, 32'(rows[i].tim), rd, err);
            apb(1'b1, OFF_MEM_CFG, 32'(rows[i].cfg), rd, err);
            cpuStart(rows[i].addr, rows[i].seq);
            waitFor(6'h10, n);
            apb(1'b0, OFF_LAST_CYCLES, 32'h0, rd, err);
            check("cycleCost", rd, 32'(rows[i].cost));
        end
        // Three requesters at once must be served in rank order
        apb(1'b1, OFF_MEM_CFG, 32'h0, rd, err);
        @(posedge mclk);
        soundReq <= 1'b1;
        refreshReq <= 1'b1;
        cpuStart(32'h0000_0000, 1'b0);
        waitFor(6'h0F, n);
        check("firstOwner", 32'(watch[3:0]), 32'h2);
        @(posedge mclk);
        soundReq <= 1'b0;
        waitFor(6'h0C, n);
        check("secondOwner", 32'(watch[3:0]), 32'h4);
        @(posedge mclk);
        refreshReq <= 1'b0;
        waitFor(6'h10, n);
        // Video raised during the slowest ROM access waits for its end
        apb(1'b1, OFF_ROM_TIMING, 32'h0, rd, err);
        apb(1'b1, OFF_MEM_CFG, 32'h3, rd, err);
        cpuStart(32'h0000_0000, 1'b0);
        waitFor(6'h08, n);
        @(posedge mclk);
        videoGo <= 1'b1;
        @(posedge mclk);
        videoGo <= 1'b0;
        waitFor(6'h11, n);
        check("cpuFinishes", 32'(watch[4]), 32'h1);
        waitFor(6'h01, n);
        waitFor(6'h20, n);
        check("firstWord", 32'(n), 32'(DATA_CYCLES) - 32'h1);
        // Video on an idle bus: synchronising stays within bound
        @(posedge mclk);
        videoGo <= 1'b1;
        @(posedge mclk);
        videoGo <= 1'b0;
        waitFor(6'h01, n);
        check("syncDelay", 32'(n <= 6), 32'h1);
        waitFor(6'h20, n);
        // A reset in mid-run must restore the timing control
        apb(1'b1, OFF_ROM_TIMING, 32'h0000_000D, rd, err);
        pulseReset();
        apb(1'b0, OFF_ROM_TIMING, 32'h0, rd, err);
        check("romTimingAgain", rd, 32'(ROM_TIMING_RST));
        wrapUp();
    end
endmodule // testbench
`default_nettype wire
